// File: sru_params.svh
`ifndef SRU_PARAMS_SVH
`define SRU_PARAMS_SVH

// Serial poll byte bit positions.
`define SRU_SP_SWEEP_IDLE   3'd0
`define SRU_SP_MOD_ON       3'd1
`define SRU_SP_PANEL_SRQ    3'd2
`define SRU_SP_SYNTH_SUM    3'd3
`define SRU_SP_OUT_AVAIL    3'd4
`define SRU_SP_EVENT_SUM    3'd5
`define SRU_SP_SRQ          3'd6
`define SRU_SP_NO_CMD       3'd7

// Standard event byte bit positions.
`define SRU_SE_QUERY_ERR    3'd2
`define SRU_SE_EXEC_ERR     3'd4
`define SRU_SE_CMD_ERR      3'd5
`define SRU_SE_KEY_PRESS    3'd6
`define SRU_SE_POWER_ON     3'd7

// Synthesizer status byte bit positions.
`define SRU_SY_TRIGGERED    3'd0
`define SRU_SY_TRIG_ERR     3'd1
`define SRU_SY_EXT_LOCK     3'd2
`define SRU_SY_CLK_ERR      3'd3
`define SRU_SY_WARM         3'd4
`define SRU_SY_TEST_ERR     3'd5
`define SRU_SY_CAL_ERR      3'd6
`define SRU_SY_MEM_ERR      3'd7

// Reset values and access masks.
`define SRU_BYTE_ZERO       8'h00
`define SRU_SE_USED_MASK    8'hf4
`define SRU_SY_STICKY_MASK  8'heb
`define SRU_SE_PON_VALUE    8'h80

// Register selects for the host read port.
`define SRU_SEL_POLL        2'd0
`define SRU_SEL_EVENT       2'd1
`define SRU_SEL_SYNTH       2'd2

// Warmup interval: two minutes at 50 MHz.
`define SRU_WARMUP_S        120
`define SRU_CLK_HZ          50000000
`define SRU_WARMUP_CYCLES   (64'd`SRU_WARMUP_S * 64'd`SRU_CLK_HZ)

`endif

// File: sru_pkg.sv
package sru_pkg;

	// Levels from the rest of the instrument, sampled through synchronisers.
	typedef struct packed {
		logic sweep_busy;
		logic mod_enabled;
		logic out_queue_nonempty;
		logic in_queue_empty;
		logic ext_ref_locked;
	} sru_levels_t;

	// One-cycle event pulses from logic on sys_clk.
	typedef struct packed {
		logic panel_srq;
		logic out_queue_overflow;
		logic exec_error;
		logic cmd_error;
		logic key_press;
		logic triggered;
		logic trig_rate_error;
		logic ext_ref_fault;
		logic self_test_fail;
		logic self_cal_fail;
		logic settings_corrupt;
	} sru_events_t;

	// Host command strobes.
	typedef struct packed {
		logic       rd;
		logic [1:0] sel;
		logic       clear_status;
		logic       wr_poll_mask;
		logic       wr_event_mask;
		logic       wr_synth_mask;
		logic [7:0] wdata;
	} sru_host_cmd_t;

	// Power-on sequencing of the mask restore.
	typedef enum logic [1:0] {
		SRU_BOOT    = 2'b00,
		SRU_RESTORE = 2'b01,
		SRU_RUN     = 2'b11
	} sru_state_t;

endpackage

// File: sru_status_unit.sv
// Behaviour
// - Keep serial poll, standard event and synthesizer status bytes, all host readable.
// - At power on masks clear or restore saved values, per stored setting.
// - Poll bit 0 high while no sweep runs.
// - Poll bit 1 high while modulation is enabled.
// - Poll bit 2 set on a front panel service request.
// - Poll bit 4 high while the output queue holds data.
// - Poll bit 7 high while no commands await execution.
// - Poll bits 3 and 5 are masked ORs of synth and event bytes.
// - Poll bit 6 shows that a service request is asserted.
// - Service request fires only on a rising enabled poll bit.
// - Event bit 2 set on output queue overflow; bits 0,1,3 unused.
// - Event bit 4 set on range or execution error.
// - Event bit 5 set on syntax error or unknown command.
// - Event bit 6 set on key press, bit 7 on power on.
// - Event bits stay set until read or clear-status.
// - Synth bit 0 set on trigger, bit 1 on trigger rate error.
// - Synth bit 2 follows external reference lock.
// - Synth bit 3 set on external reference fault.
// - Synth bit 4 set once warmup elapses and stays set.
// - Synth bits 5,6,7 set on test, cal and settings faults.
// - Other synth bits are sticky, cleared by read or clear-status.
`timescale 1ns/1ps
`include "sru_params.svh"

module sru_status_unit #(
	parameter logic [63:0] WARMUP_CYCLES = `SRU_WARMUP_CYCLES
) (
	// Clock and reset.
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	// Instrument levels from outside the clock domain.
	input  wire sru_pkg::sru_levels_t   levels,
	// Instrument event pulses on sys_clk.
	input  wire sru_pkg::sru_events_t   events,
	// Stored power-on-clear setting and saved masks.
	input  wire logic                   power_on_clear,
	input  wire logic [7:0]             saved_poll_mask,
	input  wire logic [7:0]             saved_event_mask,
	input  wire logic [7:0]             saved_synth_mask,
	// Host command port.
	input  wire sru_pkg::sru_host_cmd_t host_cmd,
	output logic [7:0]                  rdata,
	output logic                        rvalid,
	// Service request and mask readback.
	output logic                        service_request,
	output logic [7:0]                  poll_mask,
	output logic [7:0]                  event_mask,
	output logic [7:0]                  synth_mask
);
	import sru_pkg::*;

	sru_levels_t lvl_meta_reg;
	sru_levels_t lvl_sync_reg;
	sru_state_t  state_reg;
	logic [7:0]  event_reg;
	logic [7:0]  synth_reg;
	logic [7:0]  panel_reg;
	logic [63:0] warm_cnt_reg;
	logic        warm_reg;
	logic [7:0]  poll_next;
	logic [7:0]  poll_prev_reg;
	logic        srq_reg;
	logic        rd_event;
	logic        rd_synth;
	logic        rd_poll;
	logic [7:0]  event_set;
	logic [7:0]  synth_set;
	logic [7:0]  rise;
	logic        clr_event;
	logic        clr_synth;
	logic        clr_srq;

	// Place a single event pulse at a bit position of a byte.
	function automatic logic [7:0] bit_at(input logic [2:0] pos, input logic val);
		logic [7:0] b;
		b = 8'h00;
		b[pos] = val;
		return b;
	endfunction

	// Mask value taken at power on: all clear, or the copy kept over power down.
	function automatic logic [7:0] pon_mask(input logic clear_all, input logic [7:0] saved);
		return clear_all ? `SRU_BYTE_ZERO : saved;
	endfunction

	// Next value of a sticky byte; an event in the clearing cycle survives the clear.
	function automatic logic [7:0] sticky_next(input logic [7:0] cur, input logic [7:0] evt,
		input logic clr, input logic [7:0] keep);
		logic [7:0] base;
		base = clr ? `SRU_BYTE_ZERO : cur;
		return (base | evt) & keep;
	endfunction

	// First synchroniser stage for levels from outside; only the second stage reads it.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_meta_reg <= '0;
		end else begin
			lvl_meta_reg <= levels;
		end
	end

	// Second stage; every level reaches the logic two cycles late.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_sync_reg <= '0;
		end else begin
			lvl_sync_reg <= lvl_meta_reg;
		end
	end

	// Read strobes that clear sticky bytes.
	assign rd_poll  = host_cmd.rd && (host_cmd.sel == `SRU_SEL_POLL);
	assign rd_event = host_cmd.rd && (host_cmd.sel == `SRU_SEL_EVENT);
	assign rd_synth = host_cmd.rd && (host_cmd.sel == `SRU_SEL_SYNTH);

	// An event or synth read clears the byte it names, a poll read only the request bit; clear-status clears all of them.
	assign clr_event = rd_event || host_cmd.clear_status;
	assign clr_synth = rd_synth || host_cmd.clear_status;
	assign clr_srq   = rd_poll || host_cmd.clear_status;

	// Power-on sequence; the masks are restored after release, never under reset.
	// The settle cycle lets the stored masks be read once their store is out of reset.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SRU_BOOT;
		end else begin
			case (state_reg)
				SRU_BOOT:    state_reg <= SRU_RESTORE;
				SRU_RESTORE: state_reg <= SRU_RUN;
				SRU_RUN:     state_reg <= SRU_RUN;
				default:     state_reg <= SRU_BOOT;
			endcase
		end
	end

	// Writes before the run state are dropped so that no host write races the restore.
	// poll mask power-on
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_mask <= `SRU_BYTE_ZERO;
		end else if (state_reg == SRU_RESTORE) begin
			poll_mask <= pon_mask(power_on_clear, saved_poll_mask);
		end else if ((state_reg == SRU_RUN) && host_cmd.wr_poll_mask) begin
			poll_mask <= host_cmd.wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_mask <= `SRU_BYTE_ZERO;
		end else if (state_reg == SRU_RESTORE) begin
			event_mask <= pon_mask(power_on_clear, saved_event_mask);
		end else if ((state_reg == SRU_RUN) && host_cmd.wr_event_mask) begin
			event_mask <= host_cmd.wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			synth_mask <= `SRU_BYTE_ZERO;
		end else if (state_reg == SRU_RESTORE) begin
			synth_mask <= pon_mask(power_on_clear, saved_synth_mask);
		end else if ((state_reg == SRU_RUN) && host_cmd.wr_synth_mask) begin
			synth_mask <= host_cmd.wdata;
		end
	end

	// Event pulses placed at their standard event positions.
	// Bits 0, 1 and 3 are never set; the used mask holds them at zero.
	always_comb begin
		event_set = bit_at(`SRU_SE_QUERY_ERR, events.out_queue_overflow);
		event_set = event_set | bit_at(`SRU_SE_EXEC_ERR, events.exec_error);
		event_set = event_set | bit_at(`SRU_SE_CMD_ERR, events.cmd_error);
		event_set = event_set | bit_at(`SRU_SE_KEY_PRESS, events.key_press);
		event_set = event_set | bit_at(`SRU_SE_POWER_ON, state_reg == SRU_BOOT);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_reg <= `SRU_BYTE_ZERO;
		end else begin
			event_reg <= sticky_next(event_reg, event_set, clr_event, `SRU_SE_USED_MASK);
		end
	end

	// Event pulses placed at their synthesizer positions.
	// Lock and warmup are levels, so they are merged in when the byte is read.
	always_comb begin
		synth_set = bit_at(`SRU_SY_TRIGGERED, events.triggered);
		synth_set = synth_set | bit_at(`SRU_SY_TRIG_ERR, events.trig_rate_error);
		synth_set = synth_set | bit_at(`SRU_SY_CLK_ERR, events.ext_ref_fault);
		synth_set = synth_set | bit_at(`SRU_SY_TEST_ERR, events.self_test_fail);
		synth_set = synth_set | bit_at(`SRU_SY_CAL_ERR, events.self_cal_fail);
		synth_set = synth_set | bit_at(`SRU_SY_MEM_ERR, events.settings_corrupt);
	end

	// The count stops once the latch is set, so it can never wrap and clear the bit.
	// warmup cycle count
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			warm_cnt_reg <= 64'h0;
		end else if (!warm_reg) begin
			warm_cnt_reg <= warm_cnt_reg + 64'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			warm_reg <= 1'b0;
		end else if (warm_cnt_reg + 64'h1 >= WARMUP_CYCLES) begin
			warm_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			synth_reg <= `SRU_BYTE_ZERO;
		end else begin
			synth_reg <= sticky_next(synth_reg, synth_set, clr_synth, `SRU_SY_STICKY_MASK);
		end
	end

	// A poll read leaves this bit alone; only clear-status takes it away.
	// panel request latch
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			panel_reg <= `SRU_BYTE_ZERO;
		end else if (host_cmd.clear_status) begin
			panel_reg <= bit_at(`SRU_SP_PANEL_SRQ, events.panel_srq);
		end else begin
			panel_reg <= panel_reg | bit_at(`SRU_SP_PANEL_SRQ, events.panel_srq);
		end
	end

	// Serial poll byte built from levels, latches and summaries.
	// Summaries are combinational, so they fall in the very cycle that their cause clears.
	always_comb begin
		poll_next = panel_reg;
		poll_next[`SRU_SP_SWEEP_IDLE] = !lvl_sync_reg.sweep_busy;
		poll_next[`SRU_SP_MOD_ON] = lvl_sync_reg.mod_enabled;
		poll_next[`SRU_SP_OUT_AVAIL] = lvl_sync_reg.out_queue_nonempty;
		poll_next[`SRU_SP_NO_CMD] = lvl_sync_reg.in_queue_empty;
		poll_next[`SRU_SP_SYNTH_SUM] = |(synth_byte() & synth_mask);
		poll_next[`SRU_SP_EVENT_SUM] = |(event_reg & event_mask);
		poll_next[`SRU_SP_SRQ] = srq_reg;
	end

	// Full synthesizer byte with its two live level bits.
	function automatic logic [7:0] synth_byte();
		logic [7:0] b;
		b = synth_reg;
		b[`SRU_SY_EXT_LOCK] = lvl_sync_reg.ext_ref_locked;
		b[`SRU_SY_WARM]     = warm_reg;
		return b;
	endfunction

	// Rising edges of enabled poll bits; bit 6 itself is excluded to avoid a loop.
	// The history holds masked bits, so enabling a bit that is already high raises a request.
	assign rise = poll_next & ~poll_prev_reg & poll_mask & ~bit_at(`SRU_SP_SRQ, 1'b1);

	// History of the enabled poll bits for edge detection.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_prev_reg <= `SRU_BYTE_ZERO;
		end else begin
			poll_prev_reg <= poll_next & poll_mask;
		end
	end

	// A held bit cannot raise a second request; it has to fall and rise again.
	// edge-only request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			srq_reg <= 1'b0;
		end else if (state_reg != SRU_RUN) begin
			srq_reg <= 1'b0;
		end else if (|rise) begin
			srq_reg <= 1'b1;
		end else if (clr_srq) begin
			srq_reg <= 1'b0;
		end
	end

	// The pin is a registered copy of the next latch value, so it comes from a flip-flop.
	// request output pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			service_request <= 1'b0;
		end else begin
			service_request <= (state_reg == SRU_RUN) && (|rise || (srq_reg && !clr_srq));
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= host_cmd.rd;
		end
	end

	// The data shows each byte as it stood before the same edge clears it.
	// A select with no byte behind it answers zero rather than stale data.
	// host byte readback
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `SRU_BYTE_ZERO;
		end else if (host_cmd.rd) begin
			case (host_cmd.sel)
				`SRU_SEL_POLL:  rdata <= poll_next;
				`SRU_SEL_EVENT: rdata <= event_reg;
				`SRU_SEL_SYNTH: rdata <= synth_byte();
				default:        rdata <= `SRU_BYTE_ZERO;
			endcase
		end
	end

endmodule

// File: sru_status_unit_properties.sv
`timescale 1ns/1ps
module sru_status_unit_properties #(
	parameter logic [63:0] WARMUP_CYCLES = 64'd20
) (
	// Clock and reset.
	input wire logic                   sys_clk,
	input wire logic                   rst_n,
	// Inputs of the unit.
	input wire sru_pkg::sru_levels_t   levels,
	input wire sru_pkg::sru_events_t   events,
	input wire logic                   power_on_clear,
	input wire logic [7:0]             saved_event_mask,
	input wire sru_pkg::sru_host_cmd_t host_cmd,
	// Outputs of the unit.
	input wire logic [7:0]             rdata,
	input wire logic                   rvalid,
	input wire logic                   service_request,
	input wire logic [7:0]             event_mask
);
	import sru_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Read requests and a quiet cycle; event and synth reads exclude clear-status, the poll read does not.
	sequence s_poll_rd;
		host_cmd.rd && host_cmd.sel == 2'd0;
	endsequence
	sequence s_quiet;
		!host_cmd.clear_status && !host_cmd.rd;
	endsequence
	sequence s_event_rd;
		host_cmd.rd && host_cmd.sel == 2'd1 && !host_cmd.clear_status;
	endsequence
	sequence s_synth_rd;
		host_cmd.rd && host_cmd.sel == 2'd2 && !host_cmd.clear_status;
	endsequence

	property p_rvalid; 1'b1 |=> rvalid == $past(host_cmd.rd); endproperty
	property p_sel3; host_cmd.rd && host_cmd.sel == 2'd3 |=> rdata == 8'h00; endproperty
	property p_idle; (!levels.sweep_busy)[*4] ##0 s_poll_rd |=> rdata[0]; endproperty
	property p_mod; levels.mod_enabled[*4] ##0 s_poll_rd |=> rdata[1]; endproperty
	property p_srq_bit; s_poll_rd |=> rdata[6] == $past(service_request); endproperty
	property p_cmd_sticky; events.cmd_error ##1 s_quiet ##1 s_event_rd |=> rdata[5]; endproperty
	property p_trig_sticky; events.triggered ##1 s_quiet ##1 s_synth_rd |=> rdata[0]; endproperty
	property p_mask_wr;
		rst_n[*4] ##0 host_cmd.wr_event_mask |=> event_mask == $past(host_cmd.wdata);
	endproperty
	property p_pon_mask;
		$rose(rst_n) |-> ##2 event_mask == (power_on_clear ? 8'h00 : saved_event_mask);
	endproperty

	a_rvalid: assert property (p_rvalid) else $error("read answer not one cycle late");
	a_sel3: assert property (p_sel3) else $error("unmapped select read not zero");
	a_idle: assert property (p_idle) else $error("sweep idle bit low");
	a_mod: assert property (p_mod) else $error("modulation bit low");
	a_srq_bit: assert property (p_srq_bit) else $error("request bit wrong");
	a_cmd_sticky: assert property (p_cmd_sticky) else $error("command error lost");
	a_trig_sticky: assert property (p_trig_sticky) else $error("trigger flag lost");
	a_mask_wr: assert property (p_mask_wr) else $error("event mask not written");
	a_pon_mask: assert property (p_pon_mask) else $error("power on mask wrong");
endmodule

bind sru_status_unit sru_status_unit_properties #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .levels(levels), .events(events),
	.power_on_clear(power_on_clear), .saved_event_mask(saved_event_mask),
	.host_cmd(host_cmd), .rdata(rdata), .rvalid(rvalid),
	.service_request(service_request), .event_mask(event_mask));

// File: sru_host_model.sv
`timescale 1ns/1ps
module sru_host_model (
	// Clock.
	input  wire logic              sys_clk,
	// Answer from the unit.
	input  wire logic [7:0]        rdata,
	// Commands toward the unit.
	output sru_pkg::sru_host_cmd_t host_cmd
);
	import sru_pkg::*;
	initial host_cmd = '0;

	// One read; the byte arrives exactly one cycle after the request.
	task automatic read_byte(input logic [1:0] s, output logic [7:0] d);
		@(negedge sys_clk);
		host_cmd.rd = 1'b1;
		host_cmd.sel = s;
		@(negedge sys_clk);
		d = rdata;
		host_cmd.rd = 1'b0;
	endtask

	// Clear-status and mask writes, held for one whole cycle.
	task automatic strobe(input logic [3:0] f, input logic [7:0] d);
		@(negedge sys_clk);
		{host_cmd.clear_status, host_cmd.wr_poll_mask, host_cmd.wr_event_mask,
			host_cmd.wr_synth_mask} = f;
		host_cmd.wdata = d;
		@(negedge sys_clk);
		{host_cmd.clear_status, host_cmd.wr_poll_mask, host_cmd.wr_event_mask,
			host_cmd.wr_synth_mask} = 4'h0;
	endtask
endmodule

// File: status_reporting_unit_test.sv
`timescale 1ns/1ps
module status_reporting_unit_test;
	import sru_pkg::*;
	logic          sys_clk, rst_n, power_on_clear, rvalid, service_request;
	sru_levels_t   levels;
	sru_events_t   events;
	sru_host_cmd_t host_cmd;
	logic [7:0]    rdata, poll_mask, event_mask, synth_mask, d;
	int            errors = 0;
	int            n_checks = 0;

	// Warmup shortened so the bit can be seen turning on.
	sru_status_unit #(.WARMUP_CYCLES(64'd20)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.levels(levels), .events(events), .power_on_clear(power_on_clear),
		.saved_poll_mask(8'h5a), .saved_event_mask(8'ha5), .saved_synth_mask(8'h3c),
		.host_cmd(host_cmd), .rdata(rdata), .rvalid(rvalid),
		.service_request(service_request), .poll_mask(poll_mask),
		.event_mask(event_mask), .synth_mask(synth_mask));
	sru_host_model host (.sys_clk(sys_clk), .rdata(rdata), .host_cmd(host_cmd));

	// Clock of 20 ns.
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic pulse(input logic [10:0] e);
		@(negedge sys_clk);
		events = sru_events_t'(e);
		@(negedge sys_clk);
		events = '0;
	endtask
	task automatic rd_check(input logic [1:0] s, input logic [7:0] exp);
		host.read_byte(s, d);
		check(d, exp);
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic t_power_on;
		cyc(3);
		check(event_mask, 8'h00);
		rd_check(2'd1, 8'h80);
		rd_check(2'd1, 8'h00);
		rd_check(2'd2, 8'h00);
		rd_check(2'd3, 8'h00);
		$display("power_on done");
	endtask

	// Levels pass a two-flop synchroniser, so allow four cycles.
	task automatic t_levels;
		levels = sru_levels_t'(5'b01111);
		cyc(14);
		rd_check(2'd0, 8'h93);
		rd_check(2'd2, 8'h14);
		levels = sru_levels_t'(5'b10000);
		cyc(4);
		rd_check(2'd0, 8'h00);
		rd_check(2'd2, 8'h10);
		$display("levels done");
	endtask

	task automatic t_events;
		pulse(11'h3c0);
		rd_check(2'd1, 8'h74);
		rd_check(2'd1, 8'h00);
		pulse(11'h03f);
		rd_check(2'd2, 8'hfb);
		rd_check(2'd2, 8'h10);
		pulse(11'h400);
		rd_check(2'd0, 8'h04);
		rd_check(2'd0, 8'h04);
		pulse(11'h3ff);
		host.strobe(4'h8, 8'h00);
		rd_check(2'd0, 8'h00);
		rd_check(2'd1, 8'h00);
		rd_check(2'd2, 8'h10);
		$display("events done");
	endtask

	// A held summary bit must not raise a second request.
	task automatic t_srq;
		host.strobe(4'h2, 8'h20);
		check(event_mask, 8'h20);
		host.strobe(4'h4, 8'h20);
		pulse(11'h080);
		cyc(2);
		check({7'h0, service_request}, 8'h01);
		rd_check(2'd0, 8'h60);
		cyc(4);
		check({7'h0, service_request}, 8'h00);
		rd_check(2'd1, 8'h20);
		rd_check(2'd0, 8'h00);
		fork
			pulse(11'h080);
			host.read_byte(2'd1, d);
		join
		check(d, 8'h00);
		rd_check(2'd1, 8'h20);
		rd_check(2'd0, 8'h40);
		$display("srq done");
	endtask

	// Reset again mid-run, this time restoring the saved masks.
	task automatic t_restore;
		rst_n = 1'b0;
		power_on_clear = 1'b0;
		cyc(2);
		check(poll_mask, 8'h00);
		rst_n = 1'b1;
		cyc(3);
		check(poll_mask, 8'h5a);
		check(event_mask, 8'ha5);
		check(synth_mask, 8'h3c);
		rd_check(2'd1, 8'h80);
		$display("restore done");
	endtask

	initial begin
		rst_n = 1'b0;
		power_on_clear = 1'b1;
		levels = sru_levels_t'(5'b10000);
		events = '0;
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		t_power_on;
		t_levels;
		t_events;
		t_srq;
		t_restore;
		tally_and_finish;
	end

	// Watchdog against a hang.
	initial begin
		#100000;
		errors++;
		tally_and_finish;
	end
endmodule
